// File: arff_regs.vh
`ifndef ARFF_REGS_VH
`define ARFF_REGS_VH

// register slots inside one channel window (word addresses)
`define ARFF_SLOT_W          4
`define ARFF_SLOT_FACTOR     4'h0
`define ARFF_SLOT_SEED       4'h1
`define ARFF_SLOT_STATE      4'h2
`define ARFF_SLOT_FLAGS      4'h3
`define ARFF_SLOT_FLAG_BASE  4'h4

// flag control word layout
`define ARFF_CTL_TYPE_BIT    0
`define ARFF_CTL_ASSERT_LSB  4
`define ARFF_CTL_DEASSERT_LSB 12
`define ARFF_CTL_ENABLE_BIT  20

// field widths
`define ARFF_SHIFT_W         4
`define ARFF_CNT_W           8

// flag types
`define ARFF_TYPE_OVER       1'b1
`define ARFF_TYPE_UNDER      1'b0

// reset values
`define ARFF_RST_SHIFT       4'h0
`define ARFF_RST_COUNT       8'h01
`define ARFF_RST_RDATA       32'h0000_0000

`endif

// File: arff_avg.v
`timescale 1ns/1ps
`default_nettype none
`include "arff_regs.vh"

// single shared averaging datapath; the top time-shares it over channels
module arff_avg #(
    parameter DATA_W = 12
) (
    input  wire [DATA_W-1:0]        prev_i,
    input  wire [DATA_W-1:0]        sample_i,
    input  wire [`ARFF_SHIFT_W-1:0] shift_i,
    output wire [DATA_W-1:0]        next_o
);

    wire signed [DATA_W:0] prev_x;
    wire signed [DATA_W:0] samp_x;
    wire signed [DATA_W:0] sum;

    assign prev_x = {prev_i[DATA_W-1], prev_i};
    assign samp_x = {sample_i[DATA_W-1], sample_i};
    // factor is a power of two, so the division is an arithmetic shift
    assign sum = prev_x + (samp_x >>> shift_i) - (prev_x >>> shift_i);

    // factor 1 passes the raw conversion value straight through
    assign next_o = (shift_i == `ARFF_RST_SHIFT) ? sample_i
                                                 : sum[DATA_W-1:0];

endmodule // arff_avg
`default_nettype wire

// File: arff_filter_flagger.v
// Function
// - a conversion result is used only once its valid strobe shows it is complete, and it enters that channel's averager.
// - new filtered value is old plus sample over factor minus old over factor.
// - a factor of one bypasses averaging so the output equals the raw sample.
// - each channel's filter state is loaded from a programmable seed before its samples start.
// - without a programmed seed the filter state starts at zero.
// - seed and thresholds share the same signed width and format.
// - one averaging datapath is shared by all channels.
// - every configured threshold of a channel is compared with its filtered value, one raw result per flag.
// - each flag is either of over type or of under type, selecting the compare direction.
// - a flag asserts only after its assert count of consecutive hits.
// - an assert count of one makes assertion follow the raw compare.
// - an asserted flag drops only after its deassert count of consecutive misses.
// - a deassert count of one makes deassertion follow the raw compare.
// - thresholds compare as signed numbers, so negative levels work on a true scale.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "arff_regs.vh"

module arff_filter_flagger #(
    parameter CHANNELS = 4,
    parameter CHAN_W   = 2,
    parameter FLAGS    = 2,
    parameter DATA_W   = 12
) (
    input  wire                          CLK_SYS_I,
    input  wire                          RESETN_I,
    input  wire                          RES_VALID_I,
    input  wire [CHAN_W-1:0]             RES_CHAN_I,
    input  wire [DATA_W-1:0]             RES_DATA_I,
    input  wire [CHAN_W+`ARFF_SLOT_W-1:0] REG_ADDR_I,
    input  wire [31:0]                   REG_WDATA_I,
    input  wire                          REG_WR_I,
    input  wire                          REG_RD_I,
    output reg  [31:0]                   REG_RDATA_O,
    output reg                           FILT_VALID_O,
    output reg  [CHAN_W-1:0]             FILT_CHAN_O,
    output reg  [DATA_W-1:0]             FILT_DATA_O,
    output reg  [CHANNELS*FLAGS-1:0]     FLAG_O
);

    localparam NFLAG = CHANNELS * FLAGS;
    localparam CW    = `ARFF_CNT_W;
    localparam SW    = `ARFF_SHIFT_W;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // signed compare, over means reach-or-exceed, under means at-or-below
    function cmp_hit;
        input [DATA_W-1:0] value;
        input [DATA_W-1:0] level;
        input              kind;
        begin
            if (kind == `ARFF_TYPE_OVER) begin
                cmp_hit = ($signed(value) >= $signed(level));
            end else begin
                cmp_hit = ($signed(value) <= $signed(level));
            end
        end
    endfunction

    // a count of zero behaves as one so the flag cannot lock up
    function [CW-1:0] eff_count;
        input [CW-1:0] count;
        begin
            eff_count = (count == {CW{1'b0}}) ? `ARFF_RST_COUNT : count;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // storage

    reg [DATA_W-1:0] filt_state [0:CHANNELS-1];
    reg [DATA_W-1:0] seed       [0:CHANNELS-1];
    reg [SW-1:0]     fac_shift  [0:CHANNELS-1];
    reg [DATA_W-1:0] thr        [0:NFLAG-1];
    reg              kind       [0:NFLAG-1];
    reg              enable     [0:NFLAG-1];
    reg [CW-1:0]     acnt       [0:NFLAG-1];
    reg [CW-1:0]     dcnt       [0:NFLAG-1];
    reg [CW-1:0]     run        [0:NFLAG-1];

    reg              cap_valid;
    reg [CHAN_W-1:0] cap_chan;
    reg [DATA_W-1:0] cap_data;

    reg [FLAGS-1:0]    next_flag;
    reg [FLAGS*CW-1:0] next_run;
    reg [CW:0]         run_inc;
    reg [CW-1:0]       limit;
    reg                hit;
    integer            idx;
    // one loop index per process: a shared index would wake the
    // combinational blocks from each other's loops and never settle
    integer            f;
    integer            g;
    integer            h;
    integer            i;
    integer            j;

    wire [DATA_W-1:0] avg_out;

    ////////////////////////////////////////////////////////////////////////
    // register address decode

    wire [CHAN_W-1:0] reg_chan;
    wire [SW-1:0]     reg_slot;
    wire [SW-1:0]     flag_off;
    wire              flag_slot;
    wire              chan_ok;
    wire [31:0]       reg_fidx;
    wire [31:0]       reg_idx;

    assign reg_chan  = REG_ADDR_I[CHAN_W+`ARFF_SLOT_W-1:`ARFF_SLOT_W];
    assign reg_slot  = REG_ADDR_I[`ARFF_SLOT_W-1:0];
    assign flag_off  = reg_slot - `ARFF_SLOT_FLAG_BASE;
    assign reg_fidx  = {{(32-SW+1){1'b0}}, flag_off[SW-1:1]};
    assign chan_ok   = ({{(32-CHAN_W){1'b0}}, reg_chan} < CHANNELS);
    assign flag_slot = (reg_slot >= `ARFF_SLOT_FLAG_BASE) && (reg_fidx < FLAGS);
    assign reg_idx   = {{(32-CHAN_W){1'b0}}, reg_chan} * FLAGS + reg_fidx;

    ////////////////////////////////////////////////////////////////////////
    // input capture and shared averager

    // the controller runs on this clock, so no synchroniser is needed
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cap_valid <= 1'b0;
            cap_chan  <= {CHAN_W{1'b0}};
            cap_data  <= {DATA_W{1'b0}};
        end else begin
            cap_valid <= RES_VALID_I;
            if (RES_VALID_I) begin
                cap_chan <= RES_CHAN_I;
                cap_data <= RES_DATA_I;
            end
        end
    end

    arff_avg #(
        .DATA_W   (DATA_W)
    ) u_avg (
        .prev_i   (filt_state[cap_chan]),
        .sample_i (cap_data),
        .shift_i  (fac_shift[cap_chan]),
        .next_o   (avg_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // filter state, seeds and channel configuration

    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                filt_state[i] <= {DATA_W{1'b0}};
                seed[i]       <= {DATA_W{1'b0}};
                fac_shift[i]  <= `ARFF_RST_SHIFT;
            end
            FILT_VALID_O <= 1'b0;
            FILT_CHAN_O  <= {CHAN_W{1'b0}};
            FILT_DATA_O  <= {DATA_W{1'b0}};
        end else begin
            FILT_VALID_O <= cap_valid;
            if (cap_valid) begin
                filt_state[cap_chan] <= avg_out;
                FILT_CHAN_O          <= cap_chan;
                FILT_DATA_O          <= avg_out;
            end
            if (REG_WR_I && chan_ok) begin
                if (reg_slot == `ARFF_SLOT_FACTOR) begin
                    fac_shift[reg_chan] <= REG_WDATA_I[SW-1:0];
                end
                // seed write also reloads the state; it wins over a sample
                if (reg_slot == `ARFF_SLOT_SEED) begin
                    seed[reg_chan]       <= REG_WDATA_I[DATA_W-1:0];
                    filt_state[reg_chan] <= REG_WDATA_I[DATA_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag debounce, next values for the channel just filtered

    always @* begin
        next_flag = {FLAGS{1'b0}};
        next_run  = {(FLAGS*CW){1'b0}};
        run_inc   = {(CW+1){1'b0}};
        limit     = `ARFF_RST_COUNT;
        hit       = 1'b0;
        idx       = 0;
        for (f = 0; f < FLAGS; f = f + 1) begin
            idx = FILT_CHAN_O * FLAGS + f;
            hit = enable[idx] &&
                  cmp_hit(FILT_DATA_O, thr[idx], kind[idx]);
            run_inc = {1'b0, run[idx]} + {{CW{1'b0}}, 1'b1};
            if (FLAG_O[idx]) begin
                limit = eff_count(dcnt[idx]);
            end else begin
                limit = eff_count(acnt[idx]);
            end
            if (hit != FLAG_O[idx]) begin
                // count of one: run_inc is one, so the flag follows hit
                if (run_inc >= {1'b0, limit}) begin
                    next_flag[f] = hit;
                    next_run[f*CW +: CW] = {CW{1'b0}};
                end else begin
                    next_flag[f] = FLAG_O[idx];
                    next_run[f*CW +: CW] = run_inc[CW-1:0];
                end
            end else begin
                // a sample agreeing with the flag breaks the run
                next_flag[f] = FLAG_O[idx];
                next_run[f*CW +: CW] = {CW{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag state and flag configuration

    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (j = 0; j < NFLAG; j = j + 1) begin
                thr[j]    <= {DATA_W{1'b0}};
                kind[j]   <= `ARFF_TYPE_OVER;
                enable[j] <= 1'b0;
                acnt[j]   <= `ARFF_RST_COUNT;
                dcnt[j]   <= `ARFF_RST_COUNT;
                run[j]    <= {CW{1'b0}};
            end
            FLAG_O <= {NFLAG{1'b0}};
        end else begin
            if (FILT_VALID_O) begin
                for (g = 0; g < FLAGS; g = g + 1) begin
                    FLAG_O[FILT_CHAN_O*FLAGS+g] <= next_flag[g];
                    run[FILT_CHAN_O*FLAGS+g]    <= next_run[g*CW +: CW];
                end
            end
            if (REG_WR_I && chan_ok && flag_slot) begin
                if (flag_off[0] == 1'b0) begin
                    thr[reg_idx] <= REG_WDATA_I[DATA_W-1:0];
                end else begin
                    kind[reg_idx]   <= REG_WDATA_I[`ARFF_CTL_TYPE_BIT];
                    enable[reg_idx] <= REG_WDATA_I[`ARFF_CTL_ENABLE_BIT];
                    acnt[reg_idx]   <=
                        REG_WDATA_I[`ARFF_CTL_ASSERT_LSB +: CW];
                    dcnt[reg_idx]   <=
                        REG_WDATA_I[`ARFF_CTL_DEASSERT_LSB +: CW];
                    // a new control word restarts the debounce from scratch; a threshold write leaves the run count as it is
                    run[reg_idx]    <= {CW{1'b0}};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, data valid only in the cycle after the strobe

    reg [31:0] rd_mux;
    reg [FLAGS-1:0] chan_flags;

    always @* begin
        rd_mux     = `ARFF_RST_RDATA;
        chan_flags = {FLAGS{1'b0}};
        for (h = 0; h < FLAGS; h = h + 1) begin
            chan_flags[h] = FLAG_O[reg_chan*FLAGS+h];
        end
        if (chan_ok) begin
            if (reg_slot == `ARFF_SLOT_FACTOR) begin
                rd_mux[SW-1:0] = fac_shift[reg_chan];
            end else if (reg_slot == `ARFF_SLOT_SEED) begin
                rd_mux[DATA_W-1:0] = seed[reg_chan];
            end else if (reg_slot == `ARFF_SLOT_STATE) begin
                rd_mux[DATA_W-1:0] = filt_state[reg_chan];
            end else if (reg_slot == `ARFF_SLOT_FLAGS) begin
                rd_mux[FLAGS-1:0] = chan_flags;
            end else if (flag_slot) begin
                if (flag_off[0] == 1'b0) begin
                    rd_mux[DATA_W-1:0] = thr[reg_idx];
                end else begin
                    rd_mux[`ARFF_CTL_TYPE_BIT]   = kind[reg_idx];
                    rd_mux[`ARFF_CTL_ENABLE_BIT] = enable[reg_idx];
                    rd_mux[`ARFF_CTL_ASSERT_LSB +: CW]   = acnt[reg_idx];
                    rd_mux[`ARFF_CTL_DEASSERT_LSB +: CW] = dcnt[reg_idx];
                end
            end
        end
    end

    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            REG_RDATA_O <= `ARFF_RST_RDATA;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= rd_mux;
        end else begin
            REG_RDATA_O <= `ARFF_RST_RDATA;
        end
    end

endmodule // arff_filter_flagger
`default_nettype wire

// File: arff_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module arff_chk #(
    parameter CHANNELS = 4,
    parameter CHAN_W   = 2,
    parameter FLAGS    = 2,
    parameter DATA_W   = 12
) (
    input wire logic                      CLK_SYS_I,
    input wire logic                      RESETN_I,
    input wire logic                      RES_VALID_I,
    input wire logic [CHAN_W-1:0]         RES_CHAN_I,
    input wire logic [DATA_W-1:0]         RES_DATA_I,
    input wire logic [CHAN_W+3:0]         REG_ADDR_I,
    input wire logic [31:0]               REG_WDATA_I,
    input wire logic                      REG_WR_I,
    input wire logic                      REG_RD_I,
    input wire logic [31:0]               REG_RDATA_O,
    input wire logic                      FILT_VALID_O,
    input wire logic [CHAN_W-1:0]         FILT_CHAN_O,
    input wire logic [DATA_W-1:0]         FILT_DATA_O,
    input wire logic [CHANNELS*FLAGS-1:0] FLAG_O
);
    wire [3:0]   slot = REG_ADDR_I[3:0];
    logic [3:0]  k [CHANNELS];
    // shadow of the factor shifts, so bypass can be judged at the ports
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < CHANNELS; i++) k[i] <= 4'h0;
        end else if (REG_WR_I && slot == 4'h0) begin
            k[REG_ADDR_I[CHAN_W+3:4]] <= REG_WDATA_I[3:0];
        end
    end
    function automatic logic [CHANNELS*FLAGS-1:0] msk(logic [CHAN_W-1:0] c);
        return {FLAGS{1'b1}} << (c * FLAGS);
    endfunction
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    property p_lat; FILT_VALID_O == $past(RES_VALID_I, 2); endproperty
    a_lat: assert property (p_lat)
        else $error("filter valid latency wrong");
    property p_chan; FILT_VALID_O |-> FILT_CHAN_O == $past(RES_CHAN_I, 2);
    endproperty
    a_chan: assert property (p_chan)
        else $error("filter channel wrong");
    property p_hold; !FILT_VALID_O |-> $stable(FILT_DATA_O); endproperty
    a_hold: assert property (p_hold)
        else $error("filter data moved without a sample");
    property p_byp;
        FILT_VALID_O && k[FILT_CHAN_O] == 4'h0
            |-> FILT_DATA_O == $past(RES_DATA_I, 2);
    endproperty
    a_byp: assert property (p_byp)
        else $error("bypass output differs from raw sample");
    property p_fwhen; $changed(FLAG_O) |-> $past(RES_VALID_I, 3); endproperty
    a_fwhen: assert property (p_fwhen)
        else $error("flags changed without a sample");
    property p_fchan;
        ((FLAG_O ^ $past(FLAG_O)) & ~msk($past(RES_CHAN_I, 3))) == 0;
    endproperty
    a_fchan: assert property (p_fchan)
        else $error("flag of another channel changed");
    property p_idle; !$past(REG_RD_I) |-> REG_RDATA_O == 32'h0; endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside read answer");
    property p_hi;
        $past(REG_RD_I) && $past(slot) == 4'h1 |-> REG_RDATA_O[31:DATA_W] == 0;
    endproperty
    a_hi: assert property (p_hi)
        else $error("seed read has upper bits set");
    c_byp: cover property (FILT_VALID_O && k[FILT_CHAN_O] == 4'h0);
    c_rise: cover property ($rose(|FLAG_O));
    c_fall: cover property ($fell(FLAG_O[6]));
endmodule // arff_chk
bind arff_filter_flagger arff_chk #(.CHANNELS(CHANNELS), .CHAN_W(CHAN_W),
    .FLAGS(FLAGS), .DATA_W(DATA_W)) arff_chk_inst (.*);
`default_nettype wire

// File: arff_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module arff_adc (
    input wire logic   clk_i,
    output logic       valid_o,
    output logic [1:0] chan_o,
    output logic [11:0] data_o
);
    initial begin
        valid_o = 1'b0;
        chan_o = 2'h0;
        data_o = 12'h000;
    end
    // call at a rising edge; gap 0 keeps valid up for a back-to-back result
    task send(input [1:0] c, input [11:0] d, input int gap);
        valid_o <= 1'b1;
        chan_o <= c;
        data_o <= d;
        @(posedge clk_i);
        if (gap > 0) begin
            valid_o <= 1'b0;
            data_o <= ~d; // stale result must not look valid
            repeat (gap) @(posedge clk_i);
        end
    endtask
endmodule // arff_adc
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic [5:0]         addr = 6'h00;
    logic [31:0]        wdat = 32'h0;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    wire [31:0]         rdat;
    wire                fv, rv;
    wire [1:0]          fc, rc;
    wire [11:0]         fd, rdd;
    wire [7:0]          flg;
    int                 miscompares = 0, samples_checked = 0, cyc = 0;
    logic signed [11:0] st [4], thr [8];
    logic [3:0]         kf [4];
    logic [7:0]         ac [8], dc [8], run [8], pend;
    logic               ty [8], en [8], fl [8], pchk = 1'b0;
    logic [11:0]        qd [$];
    logic [7:0]         qf [$];
    logic [1:0]         qc [$];
    logic [31:0]        v32;
    always #25 clk = ~clk;
    arff_filter_flagger arff_filter_flagger_inst (.CLK_SYS_I(clk),
        .RESETN_I(rstn), .RES_VALID_I(rv), .RES_CHAN_I(rc), .RES_DATA_I(rdd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdat), .FILT_VALID_O(fv), .FILT_CHAN_O(fc),
        .FILT_DATA_O(fd), .FLAG_O(flg));
    arff_adc arff_adc_inst (.clk_i(clk), .valid_o(rv), .chan_o(rc),
        .data_o(rdd));
    ////////////////////////////////////////////////////////////
    function automatic logic [11:0] filt(logic signed [11:0] p,
                                         logic signed [11:0] d, logic [3:0] k);
        return (k == 4'h0) ? d : p + (d >>> k) - (p >>> k);
    endfunction
    task automatic upd(logic [1:0] c, logic [11:0] d);
        int i;
        logic m;
        logic [7:0] v;
        st[c] = filt(st[c], d, kf[c]);
        for (int f = 0; f < 2; f++) begin
            i = c * 2 + f;
            m = en[i] && (ty[i] ? st[c] >= thr[i] : st[c] <= thr[i]);
            if (m == fl[i]) run[i] = 8'h00;
            else if (int'(run[i]) + 1 >= (fl[i] ? dc[i] : ac[i])) begin
                fl[i] = m;
                run[i] = 8'h00;
            end else run[i] = run[i] + 8'h01;
        end
        for (int j = 0; j < 8; j++) v[j] = fl[j];
        qd.push_back(st[c]);
        qc.push_back(c);
        qf.push_back(v);
    endtask
    task automatic chk(input string n, input [31:0] s, input [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    always @(negedge clk) begin
        if (pchk) begin
            chk("flags", {24'h0, flg}, {24'h0, pend});
        end
        pchk = 1'b0;
        if (rv && rstn) upd(rc, rdd);
        if (fv) begin
            pend = qf.pop_front();
            pchk = 1'b1;
            chk("filt", {20'h0, fd}, {20'h0, qd.pop_front()});
            chk("chan", {30'h0, fc}, {30'h0, qc.pop_front()});
        end
    end
    task wreg(input [5:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input [5:0] a, output [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdat;
    endtask
    // flag 0 is over, flag 1 under; channel 0 keeps its reset seed
    task cfg(input [1:0] c, input [3:0] k, input [11:0] s, input [11:0] t0,
             input [11:0] t1, input [7:0] a, input [7:0] b);
        repeat (4) @(posedge clk);
        kf[c] = k;
        wreg({c, 4'h0}, {28'h0, k});
        if (c != 2'h0) begin
            st[c] = s;
            wreg({c, 4'h1}, {20'h0, s});
        end
        rreg({c, 4'h2}, v32);
        chk("state", v32, {20'h0, st[c]});
        for (int f = 0; f < 2; f++) begin
            thr[c*2+f] = f ? t1 : t0;
            ty[c*2+f] = !f;
            ac[c*2+f] = a;
            dc[c*2+f] = b;
            en[c*2+f] = 1'b1;
            run[c*2+f] = 8'h00;
            wreg({c, 4'h4 + 4'(2*f)}, {20'h0, thr[c*2+f]});
            wreg({c, 4'h5 + 4'(2*f)}, {11'h0, 1'b1, b, a, 3'h0, ty[c*2+f]});
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    logic [5:0]  ra [5] = '{6'h10, 6'h11, 6'h12, 6'h15, 6'h1F};
    logic [31:0] re [5] = '{32'h0, 32'h0, 32'h0, 32'h1011, 32'h0};
    logic [11:0] neg [8] = '{12'hFFF, 12'hFFE, 12'hFFC, 12'hFFB, 12'hFFF,
                             12'hFFD, 12'hFFC, 12'h005};
    initial begin
        v32 = $urandom(32'h9DF5);
        for (int i = 0; i < 8; i++) begin
            {thr[i], ty[i], ac[i], dc[i], en[i], fl[i], run[i]} =
                {12'h000, 1'b1, 8'h01, 8'h01, 1'b0, 1'b0, 8'h00};
            if (i < 4) {st[i], kf[i]} = {12'h000, 4'h0};
        end
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rreg(ra[i], v32);
            chk("reset reg", v32, re[i]);
        end
        cfg(2'h0, 4'h0, 12'h0, 12'h100, 12'hF00, 8'h01, 8'h01);
        cfg(2'h1, 4'h2, 12'h200, 12'h180, 12'h080, 8'h03, 8'h02);
        cfg(2'h2, 4'h4, 12'hE00, 12'h000, 12'hF00, 8'h04, 8'h05);
        cfg(2'h3, 4'h0, 12'h0, 12'hFFD, 12'hFF0, 8'h02, 8'h02);
        @(posedge clk);
        for (int i = 0; i < 8; i++) arff_adc_inst.send(2'h3, neg[i], i % 2);
        for (int n = 0; n < 400; n++) begin
            arff_adc_inst.send(2'($urandom), 12'($urandom), $urandom % 3);
            if (n == 200) begin
                arff_adc_inst.send(2'h0, 12'h000, 1);
                cfg(2'h1, 4'h1, 12'h7FF, 12'h0, 12'h0,
                    8'h02, 8'h03);
                @(posedge clk);
            end
        end
        arff_adc_inst.send(2'h0, 12'h000, 4);
        for (int c = 0; c < 4; c++) begin
            rreg({2'(c), 4'h3}, v32);
            chk("flag reg", v32, {30'h0, fl[c*2+1], fl[c*2]});
        end
        end_of_test();
    end
endmodule // tb
`default_nettype wire
